// >>> mcie_exec.sv
// move-class instruction executor: status copy, negate, packed copy, privileged write
`timescale 1ns/1ps
`include "mcie_map.svh"
module mcie_exec
   import mcie_pkg::*;
(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // instruction issue from operand fetch
   input  wire logic                        issue,
   input  wire logic [7:0]                  op_code,
   input  wire logic                        op_ext_vld,
   input  wire logic [7:0]                  op_ext,
   input  wire logic [127:0]                src_val,
   input  wire logic [31:0]                 sel_val,
   input  wire logic [15:0]                 len_val,
   input  wire logic [31:0]                 src_adr,
   input  wire logic [31:0]                 dst_adr,
   input  wire logic [31:0]                 processor_status_word,
   input  wire logic                        preg_exists,
   // destination operand result
   output logic                             busy,
   output logic                             done,
   output logic                             dst_we,
   output logic [127:0]                     dst_data,
   // byte memory port
   output logic                             mem_req,
   output logic                             mem_we,
   output logic [31:0]                      mem_addr,
   output logic [7:0]                       mem_wdata,
   input  wire logic [7:0]                  mem_rdata,
   input  wire logic                        mem_ack,
   // privileged register bank
   output logic                             preg_we,
   output logic [31:0]                      preg_num,
   output logic [31:0]                      preg_wdata,
   output logic [`MCIE_PREG_COUNT-1:0]      preg_fx,
   // faults
   output logic                             fault_rsvd_instr,
   output logic                             fault_rsvd_opnd
);

   mcie_state_type                  state_q, state_d;
   logic                            done_q, dst_we_q, mem_req_q, mem_we_q, preg_we_q;
   logic [127:0]                    dst_data_q;
   logic [31:0]                     mem_addr_q, preg_num_q, preg_wdata_q;
   logic [31:0]                     src_base_q, dst_base_q;
   logic [7:0]                      mem_wdata_q;
   logic [15:0]                     idx_q, cnt_q;
   logic [`MCIE_PREG_COUNT-1:0]     preg_fx_q;
   logic                            fri_q, fro_q, busy_q;

   // opcode decode
   wire take       = issue && (state_q == MCIE_IDLE);
   wire is_fd      = op_ext_vld && (op_ext == `MCIE_OP_EXT);
   wire op_status  = take && !op_ext_vld && (op_code == `MCIE_OP_STATUS);
   wire op_nb      = take && !op_ext_vld && (op_code == `MCIE_OP_NEG_BYTE);
   wire op_nw      = take && !op_ext_vld && (op_code == `MCIE_OP_NEG_WORD);
   wire op_nl      = take && !op_ext_vld && (op_code == `MCIE_OP_NEG_LONG);
   wire op_nf      = take && !op_ext_vld && (op_code == `MCIE_OP_NEG_F);
   wire op_nd      = take && !op_ext_vld && (op_code == `MCIE_OP_NEG_D);
   wire op_ng      = take && is_fd && (op_code == `MCIE_OP_NEG_F);
   wire op_nh      = take && is_fd && (op_code == `MCIE_OP_NEG_D);
   wire op_packed  = take && !op_ext_vld && (op_code == `MCIE_OP_PACKED);
   wire op_priv    = take && !op_ext_vld && (op_code == `MCIE_OP_PRIV_WR);
   wire op_float   = op_nf || op_nd || op_ng || op_nh;

   // privilege and selector checks
   wire kernel     = processor_status_word[`MCIE_MODE_HI:`MCIE_MODE_LO] == `MCIE_MODE_KERNEL;
   wire priv_bad   = op_priv && !kernel;
   wire priv_noreg = op_priv && kernel && !preg_exists;
   wire priv_ok    = op_priv && kernel && preg_exists;

   // integer negation as twos complement
   wire [7:0]   neg_b = ~src_val[7:0] + 8'h01;
   wire [15:0]  neg_w = ~src_val[15:0] + 16'h0001;
   wire [31:0]  neg_l = ~src_val[31:0] + 32'h00000001;

   // float negation flips the sign of a nonzero operand only
   wire [127:0] fmask  = op_nf ? {96'h0, 32'hFFFFFFFF} :
                         op_nh ? {128{1'b1}} : {64'h0, {64{1'b1}}};
   wire [127:0] fsrc   = src_val & fmask;
   wire         fnz    = |fsrc;
   wire [127:0] fneg   = fnz ? (fsrc ^ (128'h1 << `MCIE_FSIGN_BIT)) : fsrc;

   // destination value selection
   wire [127:0] result = op_status ? {96'h0, processor_status_word} :
                         op_nb     ? {120'h0, neg_b} :
                         op_nw     ? {112'h0, neg_w} :
                         op_nl     ? {96'h0, neg_l} :
                         op_float  ? fneg : `MCIE_ZERO_128;
   wire         writes_dst = op_status || op_nb || op_nw || op_nl || op_float;

   // packed string byte count: digits plus sign nibble, rounded to bytes
   wire [15:0]  byte_cnt  = {1'b0, len_val[15:1]} + 16'h0001;
   wire         last_byte = (idx_q + 16'h0001) == cnt_q;

   // sequencer for the packed string copy
   always_comb begin
      state_d = state_q;
      case (state_q)
         MCIE_IDLE:  if (op_packed) state_d = MCIE_READ;
         MCIE_READ:  if (mem_ack) state_d = MCIE_WRITE;
         MCIE_WRITE: if (mem_ack) state_d = last_byte ? MCIE_IDLE : MCIE_READ;
         default:    state_d = MCIE_IDLE;
      endcase
   end

   // busy tracks the next state so the registered flag stays in step with state_q
   wire         busy_d    = state_d != MCIE_IDLE;

   // state register and registered busy flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= MCIE_IDLE;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q  <= busy_d;
      end
   end

   // single-cycle instruction results
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dst_we_q   <= 1'b0;
         dst_data_q <= `MCIE_ZERO_128;
         fri_q      <= 1'b0;
         fro_q      <= 1'b0;
      end else begin
         dst_we_q   <= writes_dst;
         if (writes_dst) dst_data_q <= result;
         fri_q      <= priv_bad;
         fro_q      <= priv_noreg;
      end
   end

   // privileged register write enable, number and data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preg_we_q    <= 1'b0;
         preg_num_q   <= 32'h0;
         preg_wdata_q <= 32'h0;
      end else begin
         preg_we_q <= priv_ok;
         if (priv_ok) begin
            preg_num_q   <= sel_val;
            preg_wdata_q <= src_val[31:0];
         end
      end
   end

   // one side-effect select per implemented register
   wire [`MCIE_PREG_COUNT-1:0]  fx_hit;
   genvar gi;
   generate
      for (gi = 0; gi < `MCIE_PREG_COUNT; gi++) begin : g_fx
         assign fx_hit[gi] = priv_ok && (sel_val == 32'(gi));
      end
   endgenerate

   // side-effect strobes registered as one word, single driver
   always_ff @(posedge clk or posedge rst) begin
      if (rst) preg_fx_q <= '0;
      else preg_fx_q <= fx_hit;
   end

   // packed copy memory traffic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_req_q   <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_addr_q  <= 32'h0;
         mem_wdata_q <= 8'h00;
         idx_q       <= 16'h0;
         cnt_q       <= 16'h0;
         src_base_q  <= 32'h0;
         dst_base_q  <= 32'h0;
      end else begin
         case (state_q)
            MCIE_IDLE: if (op_packed) begin
               cnt_q      <= byte_cnt;
               idx_q      <= 16'h0;
               src_base_q <= src_adr;
               dst_base_q <= dst_adr;
               mem_req_q  <= 1'b1;
               mem_we_q   <= 1'b0;
               mem_addr_q <= src_adr;
            end
            MCIE_READ: if (mem_ack) begin
               mem_wdata_q <= mem_rdata;
               mem_we_q    <= 1'b1;
               mem_addr_q  <= dst_base_q + {16'h0, idx_q};
            end
            MCIE_WRITE: if (mem_ack) begin
               idx_q      <= idx_q + 16'h0001;
               mem_we_q   <= 1'b0;
               mem_req_q  <= !last_byte;
               mem_addr_q <= src_base_q + {16'h0, idx_q + 16'h0001};
            end
            default: mem_req_q <= 1'b0;
         endcase
      end
   end

   // completion pulse for every accepted instruction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) done_q <= 1'b0;
      else done_q <= (take && !op_packed) ||
                     (state_q == MCIE_WRITE && mem_ack && last_byte);
   end

   assign busy             = busy_q;
   assign done             = done_q;
   assign dst_we           = dst_we_q;
   assign dst_data         = dst_data_q;
   assign mem_req          = mem_req_q;
   assign mem_we           = mem_we_q;
   assign mem_addr         = mem_addr_q;
   assign mem_wdata        = mem_wdata_q;
   assign preg_we          = preg_we_q;
   assign preg_num         = preg_num_q;
   assign preg_wdata       = preg_wdata_q;
   assign preg_fx          = preg_fx_q;
   assign fault_rsvd_instr = fri_q;
   assign fault_rsvd_opnd  = fro_q;

   // checks
   a_status_copy: assert property (@(posedge clk) disable iff (rst)
      op_status |=> dst_we && dst_data == {96'h0, $past(processor_status_word)})
      else $error("status word not copied");
   a_neg_long: assert property (@(posedge clk) disable iff (rst)
      op_nl |=> dst_we && (dst_data[31:0] + $past(src_val[31:0])) == 32'h0)
      else $error("long negate wrong");
   a_neg_byte: assert property (@(posedge clk) disable iff (rst)
      op_nb |=> dst_data[127:8] == 120'h0 && (dst_data[7:0] + $past(src_val[7:0])) == 8'h0)
      else $error("byte negate wrong");
   a_fneg_sign: assert property (@(posedge clk) disable iff (rst)
      (op_nf && src_val[31:0] != 32'h0) |=>
         dst_data[31:0] == ($past(src_val[31:0]) ^ 32'h00008000))
      else $error("float sign not flipped");
   a_user_fault: assert property (@(posedge clk) disable iff (rst)
      priv_bad |=> fault_rsvd_instr && !preg_we && preg_fx == '0)
      else $error("user privileged write not faulted");
   a_preg_load: assert property (@(posedge clk) disable iff (rst)
      priv_ok |=> preg_we && preg_num == $past(sel_val) && preg_wdata == $past(src_val[31:0]))
      else $error("privileged write lost");
   a_noreg_fault: assert property (@(posedge clk) disable iff (rst)
      priv_noreg |=> fault_rsvd_opnd && !preg_we)
      else $error("missing register not faulted");
   a_fx_route: assert property (@(posedge clk) disable iff (rst)
      (priv_ok && sel_val < 32'(`MCIE_PREG_COUNT)) |=> $onehot(preg_fx))
      else $error("side effect strobe missing");
   a_copy_first: assert property (@(posedge clk) disable iff (rst)
      op_packed |=> mem_req && !mem_we && mem_addr == $past(src_adr))
      else $error("packed copy start wrong");

endmodule : mcie_exec

// >>> mcie_map.svh
// constants for the move-class instruction executor
// Operation
// - status word opcode copies whole status longword
// - integer negate stores negative, same width
// - float negate forms decoded, negated value written
// - packed string copied using one shared length
// - privileged write loads selected internal register
// - non-kernel privileged write faults, no change
// - unimplemented register selector gives operand fault in kernel mode
// - each kernel privileged write to an implemented selector below 64 routed to per-register logic
`ifndef MCIE_MAP_SVH
`define MCIE_MAP_SVH
`define MCIE_OP_STATUS     8'hDC
`define MCIE_OP_NEG_BYTE   8'h8E
`define MCIE_OP_NEG_WORD   8'hAE
`define MCIE_OP_NEG_LONG   8'hCE
`define MCIE_OP_NEG_F      8'h52
`define MCIE_OP_NEG_D      8'h72
`define MCIE_OP_EXT        8'hFD
`define MCIE_OP_PACKED     8'h34
`define MCIE_OP_PRIV_WR    8'hDA
`define MCIE_MODE_HI       25
`define MCIE_MODE_LO       24
`define MCIE_MODE_KERNEL   2'h0
`define MCIE_FSIGN_BIT     15
`define MCIE_PREG_COUNT    64
`define MCIE_ZERO_128      128'h0
`endif

// >>> mcie_pkg.sv
// types for the move-class instruction executor
package mcie_pkg;
   typedef enum logic [2:0] {
      MCIE_IDLE = 3'b001,
      MCIE_READ = 3'b010,
      MCIE_WRITE = 3'b100
   } mcie_state_type;
endpackage : mcie_pkg

// >>> mcie_mem_model.sv
// byte memory model answering the packed copy port after random delays
`timescale 1ns/1ps
module mcie_mem_model (
   // clock
   input  wire logic        clk,
   // byte memory port
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata,
   output logic             mem_ack
);
   logic [7:0] mem [256];
   int         wait_n;
   // contents follow a fixed pattern so the bench can predict them
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      wait_n = 1;
   end
   // one access per request; read data is scrambled once the ack ends
   always @(posedge clk) begin
      #1;
      if (mem_ack) begin
         mem_ack = 1'b0;
         mem_rdata = ~mem_rdata;
         wait_n = $urandom_range(3);
      end else if (mem_req && wait_n > 0) begin
         wait_n--;
      end else if (mem_req) begin
         if (mem_we) mem[mem_addr[7:0]] = mem_wdata;
         else mem_rdata = mem[mem_addr[7:0]];
         mem_ack = 1'b1;
      end
   end
endmodule : mcie_mem_model

// >>> tb_move_class_instruction_exec.sv
// self-checking bench for the move-class instruction executor
`timescale 1ns/1ps
module tb_move_class_instruction_exec;
   logic clk = 0, rst = 1, issue = 0, op_ext_vld = 0, preg_exists = 0;
   logic [7:0] op_code = 0, op_ext = 0, mem_rdata;
   logic [127:0] src_val = 0, v, e;
   logic [31:0] sel_val = 0, src_adr = 0, dst_adr = 0, processor_status_word = 0;
   logic [15:0] len_val = 0;
   logic busy, done, dst_we, mem_req, mem_we, mem_ack, preg_we;
   logic fault_rsvd_instr, fault_rsvd_opnd;
   logic [127:0] dst_data;
   logic [31:0] mem_addr, preg_num, preg_wdata;
   logic [7:0] mem_wdata;
   logic [63:0] preg_fx;
   int bad_count = 0, n_tests = 0, cyc = 0, w, md;
   logic [7:0] ops [7] = '{8'h8E, 8'hAE, 8'hCE, 8'h52, 8'h72, 8'h52, 8'h72};
   int wid [7] = '{8, 16, 32, 32, 64, 64, 128};
   mcie_exec uut (.clk(clk), .rst(rst), .issue(issue), .op_code(op_code),
      .op_ext_vld(op_ext_vld), .op_ext(op_ext), .src_val(src_val), .sel_val(sel_val),
      .len_val(len_val), .src_adr(src_adr), .dst_adr(dst_adr),
      .processor_status_word(processor_status_word), .preg_exists(preg_exists),
      .busy(busy), .done(done), .dst_we(dst_we), .dst_data(dst_data), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .preg_we(preg_we), .preg_num(preg_num), .preg_wdata(preg_wdata),
      .preg_fx(preg_fx), .fault_rsvd_instr(fault_rsvd_instr),
      .fault_rsvd_opnd(fault_rsvd_opnd));
   mcie_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   // clock and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end
   // negation result of a given width; floats flip bit 15 unless zero
   function automatic logic [127:0] neg_exp(input int wd, input logic flt,
                                            input logic [127:0] x);
      logic [127:0] m;
      m = (wd == 128) ? ~128'h0 : ((128'h1 << wd) - 128'h1);
      if (!flt) return (-x) & m;
      return ((x & m) == 128'h0) ? 128'h0 : ((x & m) ^ (128'h1 << 15));
   endfunction : neg_exp
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   // one issue strobe; returns just after the answer edge
   task automatic run(input logic [7:0] op, input logic vld, input logic [127:0] s);
      @(posedge clk);
      #1;
      op_code = op;
      op_ext_vld = vld;
      op_ext = vld ? 8'hFD : 8'h00;
      src_val = s;
      issue = 1'b1;
      @(posedge clk);
      #1;
      issue = 1'b0;
   endtask : run
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial begin
      void'($urandom(32'h71012833));
      repeat (2) @(posedge clk);
      #1 rst = 0;
      // status word copy, whole longword, zero above
      for (int i = 0; i < 4; i++) begin
         processor_status_word = (i == 0) ? 32'hFFFFFFFF : $urandom;
         run(8'hDC, 1'b0, {4{$urandom}});
         check(dst_we, 1);
         check(done, 1);
         check(dst_data, {96'h0, processor_status_word});
      end
      $display("status copy test done");
      // integer and float negate, zero and most-negative corners
      for (int i = 0; i < 42; i++) begin
         w = i % 7;
         v = (i < 7) ? 128'h0 : (i < 14) ? (128'h1 << (wid[w] - 1)) : {4{$urandom}};
         run(ops[w], w > 4, v);
         check(dst_we, 1);
         check(dst_data, neg_exp(wid[w], w > 2, v));
      end
      $display("negate test done");
      // privileged write: kernel, other modes, missing register
      for (int i = 0; i < 24; i++) begin
         md = (i == 0) ? 1 : (i < 4) ? 0 : $urandom_range(3);
         preg_exists = (i == 1) ? 1'b0 : (i < 4) ? 1'b1 : 1'($urandom);
         sel_val = (i == 2) ? 63 : (i == 3) ? 64 : $urandom_range(127);
         processor_status_word = ($urandom & 32'hFCFFFFFF) | (32'(md) << 24);
         run(8'hDA, 1'b0, {4{$urandom}});
         e = (md == 0 && preg_exists) ? 1 : 0;
         check(preg_we, e);
         check(fault_rsvd_instr, md != 0);
         check(fault_rsvd_opnd, md == 0 && !preg_exists);
         check(preg_fx, (e && sel_val < 64) ? (64'h1 << sel_val) : 64'h0);
         if (e) check({preg_num, preg_wdata}, {sel_val, src_val[31:0]});
      end
      $display("privileged write test done");
      // packed copy, byte count from the shared length
      for (int i = 0; i < 4; i++) begin
         len_val = (i == 0) ? 16'h0 : 16'($urandom_range(31));
         src_adr = 32'(i * 16);
         dst_adr = 32'(128 + i * 32);
         run(8'h34, 1'b0, 128'h0);
         check(busy, 1);
         for (int k = 0; k < 500 && done !== 1'b1; k++) @(posedge clk) #1;
         check(done, 1);
         check(busy, 0);
         for (int b = 0; b < 16; b++)
            check(mem.mem[dst_adr[7:0] + b], (b <= len_val / 2) ?
               (8'(src_adr + b) ^ 8'h5A) : (8'(dst_adr + b) ^ 8'h5A));
      end
      $display("packed copy test done");
      final_report();
   end
endmodule : tb_move_class_instruction_exec
